// ===== shared/hbs_pkg.sv
// hbs_pkg: constants, field positions, timing counts and types of the
// half-bridge serial control block.
// assumes a 100 MHz core clock; the delay counts derive from CLK_MHZ, the filter count is fixed.
package hbs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int WORD_W = 16;
    localparam int BCNT_W = 4;
    localparam int NDRV   = 6;
    localparam int NPAIR  = 3;
    localparam int CNT_W  = 16;

    ////////////////////////////////////////////////////////////////////////
    // command word fields
    localparam int CMD_OV_CUTOFF_BIT = 15;
    localparam int CMD_UL_SD_BIT     = 14;
    localparam int CMD_OC_SEL_BIT    = 13;
    localparam int CMD_CLEAR_BIT     = 0;
    localparam int DRV_LSB           = 1;
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // status word fields
    localparam int ST_SUPPLY_BIT = 15;
    localparam int ST_UL_BIT     = 14;
    localparam int ST_OC_BIT     = 13;
    localparam int ST_SHOOT_BIT  = 12;
    localparam int ST_THERM_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ          = 100;
    localparam int OC_SLOW_US       = 200;
    localparam int OC_FAST_US       = 25;
    localparam int UL_DELAY_US      = 350;
    localparam int OC_SLOW_CYC_DEF  = OC_SLOW_US * CLK_MHZ;
    localparam int OC_FAST_CYC_DEF  = OC_FAST_US * CLK_MHZ;
    localparam int UL_DELAY_CYC_DEF = UL_DELAY_US * CLK_MHZ;
    localparam int FILTER_CYC_DEF   = 16;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef logic [CNT_W-1:0]  hbs_cnt_t;
    typedef logic [NDRV-1:0]   hbs_drv_t;
    typedef logic [WORD_W-1:0] hbs_word_t;

    typedef struct packed {
        logic     csn;
        logic     sclk;
        logic     si;
        logic     wake;
        logic     vs_ov;
        logic     vs_uv;
        logic     vcc_uv;
        logic     therm;
        hbs_drv_t oc;
        hbs_drv_t ul;
    } hbs_pins_s;

    typedef enum logic {
        FR_IDLE  = 1'b0,
        FR_SHIFT = 1'b1
    } hbs_frame_e;

endpackage : hbs_pkg

// ===== shared/hbs_fault_if.sv
// hbs_fault_if: driver states and fault detector levels going to the
// fault timers, and the trip events coming back.
// assumes both ends run on core_clk.
`timescale 1ns/1ns
interface hbs_fault_if;
    import hbs_pkg::*;

    hbs_drv_t drive_on;
    hbs_drv_t oc_det;
    hbs_drv_t ul_det;
    logic     oc_delay_sel;
    hbs_drv_t oc_trip;
    hbs_drv_t ul_trip;

    modport ctrl  (output drive_on, oc_det, ul_det, oc_delay_sel,
                   input  oc_trip, ul_trip);
    modport timer (input  drive_on, oc_det, ul_det, oc_delay_sel,
                   output oc_trip, ul_trip);

endinterface : hbs_fault_if

// ===== design/hbs_fault_timer.sv
// hbs_fault_timer: per-driver overcurrent delay timers and one global
// underload delay timer.
// assumes detector levels are already synchronised to core_clk.
`timescale 1ns/1ns
module hbs_fault_timer import hbs_pkg::*; #(
    parameter int OC_SLOW_CYC  = OC_SLOW_CYC_DEF,
    parameter int OC_FAST_CYC  = OC_FAST_CYC_DEF,
    parameter int UL_DELAY_CYC = UL_DELAY_CYC_DEF
) (
    input wire logic   core_clk,
    input wire logic   reset,
    hbs_fault_if.timer fi
);

    localparam hbs_cnt_t SLOW_LIM = hbs_cnt_t'(OC_SLOW_CYC - 1);
    localparam hbs_cnt_t FAST_LIM = hbs_cnt_t'(OC_FAST_CYC - 1);
    localparam hbs_cnt_t UL_LIM   = hbs_cnt_t'(UL_DELAY_CYC - 1);

    hbs_drv_t          oc_run;
    hbs_drv_t          ul_run;
    wire  [NDRV-1:0]   oc_trip_w;
    hbs_cnt_t          ul_cnt_q;
    hbs_drv_t          ul_trip_q;

    // a fault only counts while its driver is switched on
    assign oc_run = fi.oc_det & fi.drive_on;
    assign ul_run = fi.ul_det & fi.drive_on;

    ////////////////////////////////////////////////////////////////////////
    // overcurrent: delay picked when the timer starts, then held
    genvar i;
    for (i = 0; i < NDRV; i++) begin : g_oc
        hbs_cnt_t cnt_q;
        logic     fast_q;
        logic     trip_q;
        hbs_cnt_t lim_w;

        assign lim_w = fast_q ? FAST_LIM : SLOW_LIM; // R13
        assign oc_trip_w[i] = trip_q;

        // counter restarts whenever the condition drops
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                cnt_q  <= '0;
                fast_q <= 1'b0;
                trip_q <= 1'b0;
            end else begin
                if (!oc_run[i]) begin
                    cnt_q <= '0;
                end else if (cnt_q != lim_w) begin
                    cnt_q <= cnt_q + 1'b1;
                end
                if (cnt_q == '0) begin
                    fast_q <= fi.oc_delay_sel; // R13
                end
                trip_q <= oc_run[i] & (cnt_q == lim_w); // R26
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // underload: one shared timer runs while any driver is underloaded
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ul_cnt_q  <= '0;
            ul_trip_q <= '0;
        end else begin
            if (ul_run == '0) begin
                ul_cnt_q <= '0;
            end else if (ul_cnt_q != UL_LIM) begin
                ul_cnt_q <= ul_cnt_q + 1'b1;
            end
            ul_trip_q <= (ul_cnt_q == UL_LIM) ? ul_run : '0; // R27
        end
    end

    assign fi.oc_trip = oc_trip_w;
    assign fi.ul_trip = ul_trip_q;

    // a trip never comes from a driver that was off the cycle before
    oc_trip_cause_a: // R26
        assert property (@(posedge core_clk) disable iff (reset)
            (oc_trip_w != '0) |-> ($past(oc_run) & oc_trip_w) == oc_trip_w)
        else $error("overcurrent trip without a running condition");

endmodule : hbs_fault_timer

// ===== design/hbs_spi_ctrl.sv
// hbs_spi_ctrl: serial command and status port of a triple half-bridge
// driver, with protection latches and driver enables.
// assumes all pins are asynchronous to core_clk; reset is power-on reset
// of the logic supply. shift_clock must be much slower than core_clk.
//
// Summary of operation
// R1 - frames carry 16-bit words, least significant bit first.
// R2 - chip select low opens a frame; word latches on its rising edge.
// R3 - serial output is released whenever chip select is high.
// R4 - word latches only when the bit count is a multiple of 16.
// R5 - bit counting starts at chip select fall, advances on clock rise.
// R6 - host keeps the shift clock low when raising chip select.
// R7 - an accepted frame clears the fault register; the code clears it only when command bit 0 is set.
// R8 - faults still present re-latch once the filter time has passed.
// R9 - status bits shift out while the command bits shift in.
// R10 - daisy chain: one 16-bit word per device within one frame.
// R11 - command bit 15 enables output cutoff on supply overvoltage.
// R12 - command bit 14 enables latching a driver off on underload.
// R13 - command bit 13 picks 200 us (0) or 25 us (1) overcurrent delay.
// R14 - command bits 1 to 6 switch drivers; status bits 1 to 6 echo them.
// R15 - command bit 0 set clears the latched status flags.
// R16 - status bit 15 shows a present or latched supply fault.
// R17 - status bits 14, 13, 12, 0 report underload, overcurrent, etc.
// R18 - overvoltage with cutoff enabled turns all outputs off meanwhile.
// R19 - programmed states are kept and return after overvoltage ends.
// R20 - supply fault flag stays set until a clear command.
// R21 - drivers start off and stay off in any undervoltage.
// R22 - the driver supply never affects the serial logic.
// R23 - wake pin low holds the device asleep.
// R24 - host keeps chip select high at least 5 us between frames.
// R25 - both drivers of a pair on: both forced off until cleared.
// R26 - overcurrent past the delay latches the driver off until cleared.
// R27 - underload past its delay sets a flag, optionally latches off.
// R28 - a frame of bad length changes nothing.
`timescale 1ns/1ns
module hbs_spi_ctrl import hbs_pkg::*; #(
    parameter int OC_SLOW_CYC  = OC_SLOW_CYC_DEF,
    parameter int OC_FAST_CYC  = OC_FAST_CYC_DEF,
    parameter int UL_DELAY_CYC = UL_DELAY_CYC_DEF,
    parameter int FILTER_CYC   = FILTER_CYC_DEF
) (
    input  wire logic            core_clk,
    input  wire logic            reset,
    input  wire logic            chip_select_n,
    input  wire logic            shift_clock,
    input  wire logic            serial_in,
    output logic                 serial_out,
    output logic                 serial_out_oe,
    input  wire logic            wake_pin,
    input  wire logic            vs_overvoltage,
    input  wire logic            vs_undervoltage,
    input  wire logic            vcc_undervoltage,
    input  wire logic            thermal_warn,
    input  wire logic [NDRV-1:0] overcurrent_det,
    input  wire logic [NDRV-1:0] underload_det,
    output logic                 low_side_1_on,
    output logic                 high_side_1_on,
    output logic                 low_side_2_on,
    output logic                 high_side_2_on,
    output logic                 low_side_3_on,
    output logic                 high_side_3_on
);

    localparam hbs_cnt_t FILTER_LD = hbs_cnt_t'(FILTER_CYC);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // pairs whose low and high drivers are both requested on
    function automatic logic [NPAIR-1:0] pair_conflict(input hbs_drv_t on);
        logic [NPAIR-1:0] c;
        c = '0;
        for (int k = 0; k < NPAIR; k++) begin
            c[k] = on[2*k] & on[2*k+1];
        end
        return c;
    endfunction : pair_conflict

    // expand a per-pair mask to both drivers of each pair
    function automatic hbs_drv_t pair_mask(input logic [NPAIR-1:0] p);
        hbs_drv_t m;
        m = '0;
        for (int k = 0; k < NPAIR; k++) begin
            m[2*k]   = p[k];
            m[2*k+1] = p[k];
        end
        return m;
    endfunction : pair_mask

    ////////////////////////////////////////////////////////////////////////
    // declarations
    hbs_pins_s         pin_w;
    hbs_pins_s         pin_meta_q;
    hbs_pins_s         pin_q;
    logic              sclk_prev_q;
    logic              csn_prev_q;
    hbs_frame_e        state_q;
    hbs_frame_e        state_d;
    hbs_word_t         sr_q;
    hbs_word_t         sr_d;
    logic [BCNT_W-1:0] bit_cnt_q;
    logic [BCNT_W-1:0] bit_cnt_d;
    logic              seen_q;
    logic              seen_d;
    logic              oe_q;
    logic              oe_d;
    hbs_word_t         ctrl_q;
    hbs_word_t         status_w;
    logic              supply_q;
    logic              ul_q;
    logic              oc_q;
    logic              st_q;
    logic              tw_q;
    hbs_drv_t          oc_off_q;
    hbs_drv_t          ul_off_q;
    logic [NPAIR-1:0]  blk_q;
    hbs_drv_t          drive_q;
    hbs_cnt_t          filt_q;
    logic              sclk_rise;
    logic              cs_fall;
    logic              frame_end;
    logic              len_ok;
    logic              accept;
    logic              clr;
    logic              filt_done;
    logic [NPAIR-1:0]  st_hit;
    hbs_drv_t          prog_on;
    logic              allow;
    hbs_drv_t          drive_d;

    hbs_fault_if fi ();

    hbs_fault_timer #(
        .OC_SLOW_CYC  (OC_SLOW_CYC),
        .OC_FAST_CYC  (OC_FAST_CYC),
        .UL_DELAY_CYC (UL_DELAY_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .fi       (fi.timer)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser, two flops on every outside input
    assign pin_w = '{csn: chip_select_n, sclk: shift_clock, si: serial_in,
                     wake: wake_pin, vs_ov: vs_overvoltage,
                     vs_uv: vs_undervoltage, vcc_uv: vcc_undervoltage,
                     therm: thermal_warn, oc: overcurrent_det,
                     ul: underload_det};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_meta_q  <= '0;
            pin_q       <= '0;
            sclk_prev_q <= 1'b0;
            csn_prev_q  <= 1'b0;
        end else begin
            pin_meta_q  <= pin_w;
            pin_q       <= pin_meta_q;
            sclk_prev_q <= pin_q.sclk;
            csn_prev_q  <= pin_q.csn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edges and frame decode
    assign sclk_rise = pin_q.sclk & ~sclk_prev_q;
    assign cs_fall   = ~pin_q.csn & csn_prev_q & pin_q.wake; // R23
    // the clock is low here, so no extra bit is counted at the end; R6
    assign frame_end = pin_q.csn & ~csn_prev_q & (state_q == FR_SHIFT); // R2
    assign len_ok    = seen_q & (bit_cnt_q == '0); // R4 R10
    assign accept    = frame_end & len_ok; // R4 R28
    assign clr       = accept & sr_q[CMD_CLEAR_BIT]; // R15
    assign st_hit    = accept ? pair_conflict(sr_q[DRV_LSB +: NDRV])
                              : '0; // R25
    assign filt_done = (filt_q == '0);

    // status word, snapshot taken at the start of each frame
    always_comb begin
        status_w                 = '0;
        status_w[ST_SUPPLY_BIT]  = supply_q; // R16
        status_w[ST_UL_BIT]      = ul_q; // R17
        status_w[ST_OC_BIT]      = oc_q; // R17
        status_w[ST_SHOOT_BIT]   = st_q; // R17
        status_w[ST_THERM_BIT]   = tw_q; // R17
        status_w[DRV_LSB +: NDRV] = drive_q; // R14
    end

    ////////////////////////////////////////////////////////////////////////
    // frame state machine: one shift register carries status out and the
    // command in, so surplus daisy-chain words pass straight through
    always_comb begin
        state_d   = state_q;
        sr_d      = sr_q;
        bit_cnt_d = bit_cnt_q;
        seen_d    = seen_q;
        oe_d      = oe_q;
        case (state_q)
            FR_IDLE: begin
                if (cs_fall) begin
                    state_d   = FR_SHIFT;
                    sr_d      = status_w;
                    bit_cnt_d = '0; // R5
                    seen_d    = 1'b0;
                    oe_d      = 1'b1;
                end
            end
            FR_SHIFT: begin
                if (frame_end || !pin_q.wake) begin
                    state_d = FR_IDLE;
                    oe_d    = 1'b0; // R3
                end else if (sclk_rise) begin
                    sr_d      = {pin_q.si, sr_q[WORD_W-1:1]}; // R1 R9
                    bit_cnt_d = bit_cnt_q + 1'b1; // R5
                    seen_d    = 1'b1;
                end
            end
            default: begin
                state_d = FR_IDLE;
                oe_d    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q   <= FR_IDLE;
            sr_q      <= '0;
            bit_cnt_q <= '0;
            seen_q    <= 1'b0;
            oe_q      <= 1'b0;
        end else begin
            state_q   <= state_d;
            sr_q      <= sr_d;
            bit_cnt_q <= bit_cnt_d;
            seen_q    <= seen_d;
            oe_q      <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command register, loaded only by a frame of good length
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= CTRL_RST;
        end else if (accept) begin
            ctrl_q <= sr_q; // R2 R11 R12 R13 R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault filter: a valid frame restarts it, level faults wait for it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            filt_q <= '0;
        end else if (accept) begin
            filt_q <= FILTER_LD; // R7 R8
        end else if (!filt_done) begin
            filt_q <= filt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags and latch-offs; a new event wins over a clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            supply_q <= 1'b0;
            ul_q     <= 1'b0;
            oc_q     <= 1'b0;
            st_q     <= 1'b0;
            tw_q     <= 1'b0;
            oc_off_q <= '0;
            ul_off_q <= '0;
            blk_q    <= '0;
        end else begin
            supply_q <= (supply_q & ~clr) |
                        (filt_done & (pin_q.vs_ov | pin_q.vs_uv)); // R16 R20
            tw_q     <= (tw_q & ~clr) | (filt_done & pin_q.therm); // R8
            ul_q     <= (ul_q & ~clr) | (|fi.ul_trip); // R27
            oc_q     <= (oc_q & ~clr) | (|fi.oc_trip); // R26
            st_q     <= (st_q & ~clr) | (|st_hit); // R25
            oc_off_q <= (oc_off_q & ~{NDRV{clr}}) | fi.oc_trip; // R26
            ul_off_q <= (ul_off_q & ~{NDRV{clr}}) |
                        (fi.ul_trip & {NDRV{ctrl_q[CMD_UL_SD_BIT]}}); // R12
            blk_q    <= (blk_q & ~{NPAIR{clr}}) | st_hit; // R25
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // driver enables; the programmed word is never touched by protection
    assign prog_on = ctrl_q[DRV_LSB +: NDRV] & ~oc_off_q & ~ul_off_q &
                     ~pair_mask(blk_q); // R19 R25 R26
    assign allow   = pin_q.wake & ~pin_q.vs_uv & ~pin_q.vcc_uv & // R21 R23
                     ~(pin_q.vs_ov & ctrl_q[CMD_OV_CUTOFF_BIT]); // R11 R18
    assign drive_d = allow ? prog_on : '0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            drive_q <= '0; // R21
        end else begin
            drive_q <= drive_d;
        end
    end

    // timers see actual driver state and the live delay selection
    assign fi.drive_on     = drive_q;
    assign fi.oc_det       = pin_q.oc;
    assign fi.ul_det       = pin_q.ul;
    assign fi.oc_delay_sel = ctrl_q[CMD_OC_SEL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops; serial path ignores supply state
    assign serial_out     = sr_q[0]; // R9 R22
    assign serial_out_oe  = oe_q; // R3
    assign low_side_1_on  = drive_q[0];
    assign high_side_1_on = drive_q[1];
    assign low_side_2_on  = drive_q[2];
    assign high_side_2_on = drive_q[3];
    assign low_side_3_on  = drive_q[4];
    assign high_side_3_on = drive_q[5];

    ////////////////////////////////////////////////////////////////////////
    // checks
    so_release_a: // R3
        assert property (@(posedge core_clk) disable iff (reset)
            frame_end |=> !serial_out_oe [*2])
        else $error("serial output still enabled after frame end");

    count_start_a: // R5
        assert property (@(posedge core_clk) disable iff (reset)
            (cs_fall && state_q == FR_IDLE) |=>
                (bit_cnt_q == '0) && !seen_q && serial_out_oe)
        else $error("frame count not restarted at chip select fall");

    shift_lsb_a: // R1
        assert property (@(posedge core_clk) disable iff (reset)
            (state_q == FR_SHIFT && sclk_rise && !frame_end &&
             pin_q.wake) |=>
                sr_q == {$past(pin_q.si), $past(sr_q[WORD_W-1:1])})
        else $error("serial shift not least significant bit first");

    word_latch_a: // R2
        assert property (@(posedge core_clk) disable iff (reset)
            accept |=> ctrl_q == $past(sr_q))
        else $error("accepted word not latched");

    bad_len_a: // R28
        assert property (@(posedge core_clk) disable iff (reset)
            (frame_end && !len_ok) |=> $stable(ctrl_q) && filt_q != FILTER_LD)
        else $error("bad length frame changed state");

    refilter_a: // R8
        assert property (@(posedge core_clk) disable iff (reset)
            accept |=> (filt_q == FILTER_LD) ##1 !supply_q || $past(supply_q))
        else $error("fault filter not restarted by valid frame");

    supply_hold_a: // R20
        assert property (@(posedge core_clk) disable iff (reset)
            (supply_q && !clr) |=> supply_q)
        else $error("supply flag dropped without clear command");

    ov_cutoff_a: // R18
        assert property (@(posedge core_clk) disable iff (reset)
            (pin_q.vs_ov && ctrl_q[CMD_OV_CUTOFF_BIT]) |=> drive_q == '0)
        else $error("outputs on during overvoltage cutoff");

    uv_off_a: // R21
        assert property (@(posedge core_clk) disable iff (reset)
            (pin_q.vs_uv || pin_q.vcc_uv || !pin_q.wake) |=> drive_q == '0)
        else $error("outputs on during undervoltage or sleep");

    shoot_off_a: // R25
        assert property (@(posedge core_clk) disable iff (reset)
            (blk_q != '0) |=> (drive_q & pair_mask($past(blk_q))) == '0)
        else $error("blocked pair driven after shoot-through");

    oc_latch_a: // R26
        assert property (@(posedge core_clk) disable iff (reset)
            (fi.oc_trip != '0) |=> oc_q && (oc_off_q & $past(fi.oc_trip))
                == $past(fi.oc_trip))
        else $error("overcurrent trip not latched");

endmodule : hbs_spi_ctrl

// ===== tb/hbs_host_model.sv
// hbs_host_model: serial host that frames words onto the link.
// assumes core_clk as timebase; a link half period is 8 core cycles.
`timescale 1ns/1ns
module hbs_host_model (
    input  wire logic core_clk,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    output logic      chip_select_n,
    output logic      shift_clock,
    output logic      serial_in
);
    logic so_last;
    wire  so_line = serial_out_oe ? serial_out : ~so_last;

    ////////////////////////////////////////////////////////////////////////
    // idle levels; a released output drifts away from its last value
    initial begin
        chip_select_n = 1'b1;
        shift_clock = 1'b0;
        serial_in = 1'b0;
        so_last = 1'b0;
    end
    always @(posedge core_clk) if (serial_out_oe) so_last <= serial_out;

    // one frame of n bits, least significant bit first
    task automatic xfer(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
        rx = '0;
        repeat (520) @(negedge core_clk);
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_in = tx[i];
            repeat (8) @(negedge core_clk);
            rx[i] = so_line;
            shift_clock = 1'b1;
            repeat (8) @(negedge core_clk);
            shift_clock = 1'b0;
        end
        repeat (8) @(negedge core_clk);
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    endtask : xfer
endmodule : hbs_host_model

// ===== tb/half_bridge_spi_control_tb.sv
// half_bridge_spi_control_tb: random and corner frames against the block.
// assumes shortened fault timers; host model drives the serial link.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module half_bridge_spi_control_tb;
    import hbs_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        wake_pin = 1'b1;
    logic        vs_ov = 1'b0;
    logic        therm = 1'b0, uv = 1'b0;
    logic        csn, sclk, si, so, oe;
    logic [5:0]  drv, oc = 6'h00, ul = 6'h00;
    logic [31:0] rx, seed = 32'hbdf06e25;
    hbs_word_t   w, prev;
    int          failures = 0, num_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock, design and host
    always #5 core_clk = ~core_clk;
    hbs_spi_ctrl #(.OC_SLOW_CYC(40), .OC_FAST_CYC(10), .UL_DELAY_CYC(60),
        .FILTER_CYC(4)) uut (.core_clk(core_clk), .reset(reset),
        .chip_select_n(csn), .shift_clock(sclk), .serial_in(si),
        .serial_out(so), .serial_out_oe(oe), .wake_pin(wake_pin),
        .vs_overvoltage(vs_ov), .vs_undervoltage(uv),
        .vcc_undervoltage(uv), .thermal_warn(therm),
        .overcurrent_det(oc), .underload_det(ul),
        .low_side_1_on(drv[0]), .high_side_1_on(drv[1]),
        .low_side_2_on(drv[2]), .high_side_2_on(drv[3]),
        .low_side_3_on(drv[4]), .high_side_3_on(drv[5]));
    hbs_host_model host (.core_clk(core_clk), .serial_out(so),
        .serial_out_oe(oe), .chip_select_n(csn), .shift_clock(sclk),
        .serial_in(si));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // drop the high side of any pair asked to turn fully on
    function automatic hbs_word_t legal(input hbs_word_t v);
        for (int p = 0; p < NPAIR; p++)
            if (v[1 + 2 * p] & v[2 + 2 * p]) v[2 + 2 * p] = 1'b0;
        return v;
    endfunction : legal
    task automatic fr(input logic [31:0] tx, input int n, hbs_word_t e);
        host.xfer(tx, n, rx);
        repeat (20) @(negedge core_clk);
        `CHK(rx[15:0], e)
        `CHK(oe, 1'b0)
    endtask : fr
    task automatic tally_and_finish();
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    // watchdog on the whole run
    initial begin
        repeat (60000) @(negedge core_clk);
        failures++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        `CHK(drv, 6'h00)
        prev = 16'h0000;
        for (int k = 0; k < 6; k++) begin
            w = legal(hbs_word_t'(xs())) | 16'h0001;
            fr(w, 16, prev & 16'h007e);
            `CHK(drv, w[6:1])
            prev = w;
        end
        for (int n = 15; n <= 17; n += 2) begin
            fr(xs(), n, prev & 16'h007e);
            `CHK(drv, prev[6:1])
        end
        w = legal(hbs_word_t'(xs()));
        fr({w, 16'ha5c3}, 32, prev & 16'h007e);
        `CHK(rx[31:16], 16'ha5c3)
        `CHK(drv, w[6:1])
        fr(32'h0007, 16, w & 16'h007e);
        `CHK(drv, 6'h00)
        fr(32'h0004, 16, 16'h1000);
        `CHK(drv, 6'h00)
        fr(32'h0001, 16, 16'h1000);
        fr(32'h0004, 16, 16'h0000);
        `CHK(drv, 6'h02)
        prev = 16'h0004;
        for (int en = 0; en < 2; en++) begin
            fr(hbs_word_t'(en << 15) | 16'h000b, 16, prev & 16'h007e);
            vs_ov = 1'b1;
            therm = 1'b1;
            repeat (40) @(negedge core_clk);
            `CHK(drv, (en != 0) ? 6'h00 : 6'h05)
            vs_ov = 1'b0;
            therm = 1'b0;
            repeat (40) @(negedge core_clk);
            `CHK(drv, 6'h05)
            fr(32'h000b, 16, 16'h800b);
            prev = 16'h000b;
        end
        fr(32'h000a, 16, 16'h000a);
        wake_pin = 1'b0;
        repeat (40) @(negedge core_clk);
        `CHK(drv, 6'h00)
        host.xfer(32'h0041, 16, rx);
        wake_pin = 1'b1;
        repeat (40) @(negedge core_clk);
        `CHK(drv, 6'h05)
        fr(32'h2003, 16, 16'h000a);
        oc = 6'h01;
        repeat (30) @(negedge core_clk);
        `CHK(drv, 6'h00)
        oc = 6'h00;
        fr(32'h4003, 16, 16'h2000);
        `CHK(drv, 6'h01)
        for (int en = 0; en < 2; en++) begin
            ul = 6'h01;
            repeat (80) @(negedge core_clk);
            `CHK(drv, (en != 0) ? 6'h01 : 6'h00)
            ul = 6'h00;
            fr(32'h0003, 16, (en != 0) ? 16'h4002 : 16'h4000);
        end
        uv = 1'b1;
        repeat (40) @(negedge core_clk);
        `CHK(drv, 6'h00)
        uv = 1'b0;
        repeat (40) @(negedge core_clk);
        `CHK(drv, 6'h01)
        tally_and_finish();
    end
endmodule : half_bridge_spi_control_tb
